// File: hdl/irq_ctrl_params.svh
/*
  Offsets, field positions, reset values and vector figures of the
  prioritized interrupt controller.
  Assumes it is included by bare name from the design file.
*/
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH

// register offsets
`define OFS_EXT_PENDING   8'hA0
`define OFS_EDGE_SEL_LOW  8'hA4
`define OFS_EDGE_SEL_HIGH 8'hA5
`define OFS_ENABLE_A      8'hA8
`define OFS_ENABLE_B      8'hA9
`define OFS_ENABLE_C      8'hAA
`define OFS_ENABLE_D      8'hAB
`define OFS_LEVEL_LOW     8'hB8
`define OFS_LEVEL_HIGH    8'hF8

// reset values
`define RST_REG           8'h00

// implemented bits per register
`define MASK_EXT_PENDING  8'h3F
`define MASK_EDGE_LOW     8'hFF
`define MASK_EDGE_HIGH    8'h0F
`define MASK_ENABLE_A     8'hBF
`define MASK_ENABLE_B     8'h0D
`define MASK_ENABLE_C     8'h37
`define MASK_ENABLE_D     8'h18
`define MASK_LEVEL        8'h3F

// field positions
`define POS_GLOBAL_GATE   7

// edge select codes
`define EDGE_NONE         2'h0
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3

// vector figures
`define VEC_BASE          16'h0003
`define VEC_SHIFT         3

`endif

// File: hdl/irq_ctrl_pkg.sv
/*
  Types of the prioritized interrupt controller.
  Assumes no other package; used by full scoped names only.
*/
package irq_ctrl_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_bus_t;

    typedef struct packed {
        logic last_cycle;
        logic ack;
        logic reti;
    } cpu_ctl_t;

    typedef struct packed {
        logic        irq;
        logic [15:0] vector;
    } cpu_req_t;

    typedef struct packed {
        logic       found;
        logic [4:0] id;
        logic [1:0] level;
    } winner_t;

endpackage : irq_ctrl_pkg

// File: hdl/prioritized_interrupt_controller.sv
/*
  Prioritized interrupt controller: 24 sources, six level groups,
  six edge-detected external pins, vector hand-over to the cpu core.
  Assumes a cpu core that marks the last cycle of each instruction,
  acknowledges in the first cycle of the next and signals return.
*/
// Our own choice: the address-and-strobe port.
// Operation
// - sample at last cycle, fix vector
// - top enable bit gates all sources
// - enable a bits 0-5 for pins
// - enable b: converter, line rx, tx
// - enable c: timers, siren, usart rx/tx
// - enable d: watchdog, interval timer
// - 24 sources in six groups of four
// - level from high and low bit
// - level registers clear on reset
// - equal level: lower number wins
// - selected edge sets pin pending flag
// - pending clears by zero write, ack
// - low edge select: pins 0-3 fields
// - codes none, rise, fall, both
// - high edge select: pins 4, 5
// - edge selects reset to none
// - deliver only gated and enabled; auto-clear
// - only strictly higher level preempts
// - vector is 3 plus 8 times number
module prioritized_interrupt_controller #(
    parameter int N_SRC = 24,
    parameter int N_EXT = 6
) (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire irq_ctrl_pkg::reg_bus_t   bus_i,
    output      logic [7:0]               rdata_o,
    input  wire irq_ctrl_pkg::cpu_ctl_t   cpu_i,
    output      irq_ctrl_pkg::cpu_req_t   cpu_o,
    output      logic [4:0]               irq_id_o,
    input  wire logic [N_EXT-1:0]         ext_pin_i,
    input  wire logic [N_SRC-1:N_EXT]     periph_req_i
);
`include "irq_ctrl_params.svh"

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [2:0] group_of(input logic [4:0] k);
        group_of = 3'(k % 5'd6);
    endfunction : group_of

    function automatic logic [1:0] level_of(input logic [4:0] k,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [2:0] g;
        g = group_of(k);
        level_of = {hi[g], lo[g]};
    endfunction : level_of

    function automatic logic [1:0] top_level(input logic [3:0] act);
        top_level = 2'd0;
        for (int i = 0; i < 4; i++)
        begin
            if (act[i])
            begin
                top_level = 2'(i);
            end
        end
    endfunction : top_level

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] source_enable_a;
    logic [7:0] source_enable_b;
    logic [7:0] source_enable_c;
    logic [7:0] source_enable_d;
    logic [7:0] group_level_low_bits;
    logic [7:0] group_level_high_bits;
    logic [7:0] pin_edge_select_low;
    logic [7:0] pin_edge_select_high;
    logic [N_SRC-1:0] req_flag;
    logic [3:0] in_service;
    logic [1:0] cur_level;
    logic [N_EXT-1:0] sync1;
    logic [N_EXT-1:0] sync2;
    logic [N_EXT-1:0] sync3;
    logic [N_EXT-1:0] pin_level;

    logic wr_hit;
    assign wr_hit = bus_i.wr;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            source_enable_a       <= `RST_REG;
            source_enable_b       <= `RST_REG;
            source_enable_c       <= `RST_REG;
            source_enable_d       <= `RST_REG;
            group_level_low_bits  <= `RST_REG;
            group_level_high_bits <= `RST_REG;
            pin_edge_select_low   <= `RST_REG;
            pin_edge_select_high  <= `RST_REG;
        end
        else if (wr_hit)
        begin
            if (bus_i.addr == `OFS_ENABLE_A)
            begin
                source_enable_a <= bus_i.wdata & `MASK_ENABLE_A;
            end
            else if (bus_i.addr == `OFS_ENABLE_B)
            begin
                source_enable_b <= bus_i.wdata & `MASK_ENABLE_B;
            end
            else if (bus_i.addr == `OFS_ENABLE_C)
            begin
                source_enable_c <= bus_i.wdata & `MASK_ENABLE_C;
            end
            else if (bus_i.addr == `OFS_ENABLE_D)
            begin
                source_enable_d <= bus_i.wdata & `MASK_ENABLE_D;
            end
            else if (bus_i.addr == `OFS_LEVEL_LOW)
            begin
                group_level_low_bits <= bus_i.wdata & `MASK_LEVEL;
            end
            else if (bus_i.addr == `OFS_LEVEL_HIGH)
            begin
                group_level_high_bits <= bus_i.wdata & `MASK_LEVEL;
            end
            else if (bus_i.addr == `OFS_EDGE_SEL_LOW)
            begin
                pin_edge_select_low <= bus_i.wdata & `MASK_EDGE_LOW;
            end
            else if (bus_i.addr == `OFS_EDGE_SEL_HIGH)
            begin
                pin_edge_select_high <= bus_i.wdata & `MASK_EDGE_HIGH;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read, data in the cycle after the strobe only

    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (bus_i.addr == `OFS_EXT_PENDING)
        begin
            next_rdata = {2'b00, req_flag[N_EXT-1:0]};
        end
        else if (bus_i.addr == `OFS_EDGE_SEL_LOW)
        begin
            next_rdata = pin_edge_select_low;
        end
        else if (bus_i.addr == `OFS_EDGE_SEL_HIGH)
        begin
            next_rdata = pin_edge_select_high;
        end
        else if (bus_i.addr == `OFS_ENABLE_A)
        begin
            next_rdata = source_enable_a;
        end
        else if (bus_i.addr == `OFS_ENABLE_B)
        begin
            next_rdata = source_enable_b;
        end
        else if (bus_i.addr == `OFS_ENABLE_C)
        begin
            next_rdata = source_enable_c;
        end
        else if (bus_i.addr == `OFS_ENABLE_D)
        begin
            next_rdata = source_enable_d;
        end
        else if (bus_i.addr == `OFS_LEVEL_LOW)
        begin
            next_rdata = group_level_low_bits;
        end
        else if (bus_i.addr == `OFS_LEVEL_HIGH)
        begin
            next_rdata = group_level_high_bits;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= bus_i.rd ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and edge detect

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1     <= '0;
            sync2     <= '0;
            sync3     <= '0;
            pin_level <= '0;
        end
        else
        begin
            sync1 <= ext_pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int n = 0; n < N_EXT; n++)
            begin
                if (sync2[n] == sync3[n])
                begin
                    pin_level[n] <= sync3[n];
                end
            end
        end
    end

    logic [11:0] edge_fields;
    logic [N_EXT-1:0] ext_set;

    assign edge_fields = {pin_edge_select_high[3:0], pin_edge_select_low};

    always_comb
    begin
        logic rise;
        logic fall;
        logic [1:0] sel;
        rise = 1'b0;
        fall = 1'b0;
        sel  = `EDGE_NONE;
        for (int n = 0; n < N_EXT; n++)
        begin
            sel  = edge_fields[2*n +: 2];
            rise = (sync2[n] == sync3[n]) && sync3[n] && !pin_level[n];
            fall = (sync2[n] == sync3[n]) && !sync3[n] && pin_level[n];
            ext_set[n] = ((sel == `EDGE_RISE) && rise) || ((sel == `EDGE_FALL) && fall)
                || ((sel == `EDGE_BOTH) && (rise || fall));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request flags, set wins over clear

    logic [N_SRC-1:0] set_vec;
    logic [N_SRC-1:0] clr_vec;
    logic             ack_take;

    assign ack_take = cpu_i.ack && cpu_o.irq;
    assign set_vec  = {periph_req_i, ext_set};

    always_comb
    begin
        clr_vec = '0;
        if (wr_hit && (bus_i.addr == `OFS_EXT_PENDING))
        begin
            clr_vec[N_EXT-1:0] = ~bus_i.wdata[N_EXT-1:0];
        end
        if (ack_take)
        begin
            clr_vec[irq_id_o] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            req_flag <= '0;
        end
        else
        begin
            req_flag <= (req_flag & ~clr_vec) | set_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // selection

    logic [N_SRC-1:0]      enable_vec;
    logic [N_SRC-1:0]      eligible;
    irq_ctrl_pkg::winner_t win;

    assign enable_vec = {source_enable_d[5:0], source_enable_c[5:0],
                         source_enable_b[5:0], source_enable_a[5:0]};

    always_comb
    begin
        for (int k = 0; k < N_SRC; k++)
        begin
            eligible[k] = req_flag[k] && enable_vec[k]
                && source_enable_a[`POS_GLOBAL_GATE];
        end
    end

    always_comb
    begin
        logic [1:0] lv;
        lv  = 2'd0;
        win = '0;
        for (int k = N_SRC - 1; k >= 0; k--)
        begin
            lv = level_of(5'(k), group_level_low_bits, group_level_high_bits);
            if (eligible[k] && (!win.found || lv >= win.level))
            begin
                win.found = 1'b1;
                win.id    = 5'(k);
                win.level = lv;
            end
        end
    end

    logic preempt_ok;
    assign preempt_ok = (in_service == 4'h0) || (win.level > top_level(in_service));

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cpu_o     <= '0;
            irq_id_o  <= 5'd0;
            cur_level <= 2'd0;
        end
        else if (cpu_i.last_cycle)
        begin
            cpu_o.irq    <= win.found && preempt_ok;
            cpu_o.vector <= `VEC_BASE + (16'(win.id) << `VEC_SHIFT);
            irq_id_o     <= win.id;
            cur_level    <= win.level;
        end
        else if (ack_take)
        begin
            cpu_o.irq <= 1'b0;
        end
    end

    logic [3:0] next_in_service;

    always_comb
    begin
        next_in_service = in_service;
        if (cpu_i.reti)
        begin
            next_in_service[top_level(in_service)] = 1'b0;
        end
        if (ack_take)
        begin
            next_in_service[cur_level] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            in_service <= 4'h0;
        end
        else
        begin
            in_service <= next_in_service;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence granted_s;
        cpu_o.irq && cpu_i.ack && !cpu_i.last_cycle;
    endsequence

    sequence sampled_s;
        cpu_i.last_cycle && win.found && preempt_ok;
    endsequence

    AST_VECTOR_FORMULA: assert property (cpu_o.irq |->
        cpu_o.vector == 16'h0003 + 16'(irq_id_o) * 16'h0008)
        else $error("vector differs from base plus eight times number");

    AST_VECTOR_ONLY_AT_SAMPLE: assert property (!cpu_i.last_cycle |=>
        $stable(cpu_o.vector))
        else $error("vector moved outside the last instruction cycle");

    AST_SAMPLE_RAISES: assert property (sampled_s |=> cpu_o.irq && (irq_id_o == $past(win.id)))
        else $error("eligible request not presented after sampling");

    AST_GATE_CLOSED: assert property (cpu_i.last_cycle && !source_enable_a[7] |=> !cpu_o.irq)
        else $error("request delivered with global gate closed");

    AST_ACK_CLEARS: assert property (granted_s ##0 !set_vec[irq_id_o] |=>
        !cpu_o.irq && !req_flag[$past(irq_id_o)])
        else $error("acknowledge did not clear request");

    AST_WRITE_ONE_KEEPS: assert property (bus_i.wr && bus_i.addr == 8'hA0
        && bus_i.wdata[5:0] == 6'h3F && !ack_take |=>
        (($past(req_flag[5:0]) & ~req_flag[5:0]) == 6'h00))
        else $error("writing one altered a pending flag");

    AST_EDGE_SETS: assert property (ext_set != 6'h00 |=>
        ((req_flag[5:0] & $past(ext_set)) == $past(ext_set)))
        else $error("qualifying edge lost");

    AST_NONE_NO_SET: assert property (edge_fields[1:0] == 2'b00 |-> !ext_set[0])
        else $error("pin 0 set with edge detection off");

    AST_PREEMPT_STRICT: assert property (cpu_i.last_cycle && in_service != 4'h0
        && win.level <= top_level(in_service) |=> !cpu_o.irq)
        else $error("equal or lower level preempted a routine");

    AST_READ_WINDOW: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside its cycle");

endmodule : prioritized_interrupt_controller

// File: test/cpu_core_model.sv
/*
  Behavioural cpu core seen from the interrupt controller: four-cycle
  instructions, acknowledge in the first cycle after a sampled request.
  Assumes one system clock and the controller's cpu handshake ports.
*/
module cpu_core_model (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire irq_ctrl_pkg::cpu_req_t req_i,
    input  wire logic                   reti_i,
    output      irq_ctrl_pkg::cpu_ctl_t ctl_o,
    output      logic [15:0]            got_vector_o,
    output      logic [7:0]             got_count_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] phase;
    logic       after_last;

    ////////////////////////////////////////////////////////////////////////////
    // instruction sequencing
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            phase      <= 2'h0;
            after_last <= 1'b0;
        end
        else
        begin
            phase      <= phase + 2'h1;
            after_last <= (phase == 2'h3);
        end
    end

    assign ctl_o.last_cycle = (phase == 2'h3);
    assign ctl_o.ack        = after_last & req_i.irq;
    assign ctl_o.reti       = reti_i;

    ////////////////////////////////////////////////////////////////////////////
    // vector taken for the long call
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            got_vector_o <= 16'h0000;
            got_count_o  <= 8'h00;
        end
        else if (ctl_o.ack)
        begin
            got_vector_o <= req_i.vector;
            got_count_o  <= got_count_o + 8'h01;
        end
    end
endmodule : cpu_core_model

// File: test/tb_prioritized_interrupt_controller.sv
/*
  Self-checking bench: register access, pin edges, delivery and priority.
  Assumes the cpu core model and a 40 MHz system clock.
*/
module tb_prioritized_interrupt_controller;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clk;
    logic                   rstn;
    irq_ctrl_pkg::reg_bus_t bus;
    logic [7:0]             rdata;
    irq_ctrl_pkg::cpu_ctl_t ctl;
    irq_ctrl_pkg::cpu_req_t req;
    logic [4:0]             irq_id;
    logic [5:0]             pins;
    logic [23:6]            preq;
    logic                   reti;
    logic [15:0]            got_vec;
    logic [7:0]             got_cnt;
    int                     fails;
    int                     tests_run;
    logic [7:0]             addrs [8] = '{8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hB8, 8'hF8, 8'hA4, 8'hA5};
    logic [7:0]             masks [8] = '{8'hBF, 8'h0D, 8'h37, 8'h18, 8'h3F, 8'h3F, 8'hFF, 8'h0F};
    int                     srcs [10] = '{6, 8, 9, 12, 13, 14, 16, 17, 21, 22};

    prioritized_interrupt_controller prioritized_interrupt_controller_inst (
        .clk_i        (clk),
        .rstn_i       (rstn),
        .bus_i        (bus),
        .rdata_o      (rdata),
        .cpu_i        (ctl),
        .cpu_o        (req),
        .irq_id_o     (irq_id),
        .ext_pin_i    (pins),
        .periph_req_i (preq)
    );

    cpu_core_model cpu_core_model_inst (
        .clk_i        (clk),
        .rstn_i       (rstn),
        .req_i        (req),
        .reti_i       (reti),
        .ctl_o        (ctl),
        .got_vector_o (got_vec),
        .got_count_o  (got_cnt)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic stop_test();
        $display("comparisons %0d, errors %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp});
    endtask : rd_chk

    task automatic take(input logic [15:0] exp);
        logic [7:0] c0;
        c0 = got_cnt;
        for (int i = 0; i < 60 && got_cnt === c0; i++)
            @(posedge clk);
        if (got_cnt === c0)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, 16'h0000, exp);
            stop_test();
        end
        else
        begin
            #1 check(got_vec, exp);
            check({11'h000, irq_id}, (exp - 16'h0003) >> 3);
            check({15'h0000, req.irq}, 16'h0000);
        end
    endtask : take

    task automatic none(input int n);
        logic [7:0] c0;
        c0 = got_cnt;
        repeat (n) @(posedge clk);
        check({8'h00, got_cnt}, {8'h00, c0});
    endtask : none

    task automatic ret();
        @(posedge clk);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
    endtask : ret

    task automatic pulse2(input int a, input int b);
        logic [23:6] v;
        v    = '0;
        v[a] = 1'b1;
        v[b] = 1'b1;
        @(posedge clk);
        preq <= v;
        @(posedge clk);
        preq <= '0;
    endtask : pulse2

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [7:0] sa;
        rstn = 1'b0;
        bus = '0;
        pins = '0;
        preq = '0;
        reti = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk(addrs[i], 8'h00);
        rd_chk(8'hA0, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(addrs[i], 8'hFF);
            rd_chk(addrs[i], masks[i]);
            wr(addrs[i], 8'h00);
        end
        wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00);
        wr(8'hA0, 8'hFF);
        rd_chk(8'hA0, 8'h00);
        // every pin with every edge code
        for (int p = 0; p < 6; p++)
            for (int c = 0; c < 4; c++)
            begin
                sa = (p < 4) ? 8'hA4 : 8'hA5;
                wr(sa, 8'(c << (2 * (p % 4))));
                @(posedge clk);
                pins[p] <= 1'b1;
                repeat (8) @(posedge clk);
                wr(8'hA0, 8'hFF);
                rd_chk(8'hA0, 8'(c & 1) << p);
                wr(8'hA0, 8'h00);
                @(posedge clk);
                pins[p] <= 1'b0;
                repeat (8) @(posedge clk);
                rd_chk(8'hA0, 8'((c >> 1) & 1) << p);
                wr(8'hA0, 8'h00);
                rd_chk(8'hA0, 8'h00);
                wr(sa, 8'h00);
            end
        // gate closed, then opened
        wr(8'hA4, 8'h01);
        wr(8'hA8, 8'h01);
        @(posedge clk);
        pins[0] <= 1'b1;
        none(30);
        wr(8'hA8, 8'h81);
        take(16'h0003);
        rd_chk(8'hA0, 8'h00);
        ret();
        // every enabled peripheral source
        wr(8'hA9, 8'h0D);
        wr(8'hAA, 8'h37);
        wr(8'hAB, 8'h18);
        foreach (srcs[i])
        begin
            pulse2(srcs[i], srcs[i]);
            take(16'h0003 + 16'(8 * srcs[i]));
            ret();
        end
        pulse2(7, 7);
        none(30);
        // same level: lower number first, equal level waits
        pulse2(8, 13);
        take(16'h0043);
        none(30);
        ret();
        take(16'h006B);
        ret();
        // group 1 at level 2 wins and is not preempted by level 0
        wr(8'hF8, 8'h02);
        pulse2(8, 13);
        take(16'h006B);
        none(30);
        ret();
        take(16'h0043);
        ret();
        // group 2 at level 3 beats level 2
        wr(8'hB8, 8'h04);
        wr(8'hF8, 8'h06);
        pulse2(8, 13);
        take(16'h0043);
        ret();
        take(16'h006B);
        ret();
        // level 2 routine preempted by level 3
        pulse2(13, 13);
        take(16'h006B);
        pulse2(8, 8);
        take(16'h0043);
        ret();
        ret();
        stop_test();
    end
endmodule : tb_prioritized_interrupt_controller
